// ===== hw/telemetry_readout_and_channel_config.sv
`timescale 1ns/100ps
// Overview of operation
// - input voltage read returns latest linear-11 sample
// - output voltage read returns latest sample, linear-16 unless hires
// - odd hires channel reads linear-11 millivolts
// - temperature read returns latest linear-11 sample
// - revision read-only, always 0x11
// - config top nibble ignores writes, reads zero
// - bit 11 zero enables fast servo
// - bit 10 selects supervisor resolution
// - bit 9 hires only on odd channels
// - bit 8 selects control pin
// - bit 7 continuous servo, dac mode 00
// - bit 6 re-servo on warning, limited
// - one config word per channel
// - dac mode field governs dac use
module telemetry_readout_and_channel_config
  import telemetry_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // command port from the serial protocol engine
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_code,
  input wire logic [telemetry_pkg::CH_W-1:0] cmd_page,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_error,
  // conversion results from the adc sequencer
  input wire logic adc_vin_valid,
  input wire logic [15:0] adc_vin_l11,
  input wire logic adc_vout_valid,
  input wire logic [telemetry_pkg::CH_W-1:0] adc_vout_ch,
  input wire logic [15:0] adc_vout_data,
  input wire logic adc_temp_valid,
  input wire logic [15:0] adc_temp_l11,
  // control pins
  input wire logic control_pin_zero,
  input wire logic control_pin_one,
  // decoded per-channel controls
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] fast_servo_en,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] supervisor_coarse,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] adc_hires,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] channel_control,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] servo_continuous,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] servo_on_warn,
  output logic [2*telemetry_pkg::NUM_CHANNELS-1:0] dac_mode,
  output logic [telemetry_pkg::NUM_CHANNELS-1:0] vout_format
);
  import telemetry_pkg::*;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // hires current sensing exists only on odd channels
  function automatic logic hires_of(input logic [15:0] cfg, input int unsigned ch);
    hires_of = cfg[CFG_ADC_HIRES] & (ch[0] == 1'b1);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] vin_q, vin_d;                       // latest input voltage word
  logic [15:0] temp_q, temp_d;                     // latest junction temperature word
  logic [15:0] vout_q [NUM_CHANNELS];              // latest per-channel output words
  logic [15:0] vout_d [NUM_CHANNELS];
  logic [15:0] cfg_q [NUM_CHANNELS];               // per-channel configuration words
  logic [15:0] cfg_d [NUM_CHANNELS];
  logic [15:0] rdata_q, rdata_d;                   // read answer
  logic rvalid_q, rvalid_d;                        // answer strobe
  logic error_q, error_d;                          // unsupported command strobe
  logic [NUM_CHANNELS-1:0] fast_q, fast_d;
  logic [NUM_CHANNELS-1:0] sup_q, sup_d;
  logic [NUM_CHANNELS-1:0] hires_q, hires_d;
  logic [NUM_CHANNELS-1:0] ctl_q, ctl_d;
  logic [NUM_CHANNELS-1:0] cont_q, cont_d;
  logic [NUM_CHANNELS-1:0] warn_q, warn_d;
  logic [2*NUM_CHANNELS-1:0] mode_q, mode_d;
  logic [NUM_CHANNELS-1:0] fmt_q, fmt_d;

  // ****************************************************************
  // telemetry capture
  // ****************************************************************

  // whole words are latched in one edge, so a read never mixes two conversions
  always_comb begin
    vin_d = vin_q;
    temp_d = temp_q;
    if (adc_vin_valid) begin
      vin_d = adc_vin_l11;
    end
    if (adc_temp_valid) begin
      temp_d = adc_temp_l11;
    end
  end

  // sequencer already formats the word per channel mode; we only store it
  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      vout_d[i] = vout_q[i];
      if (adc_vout_valid && (adc_vout_ch == i[CH_W-1:0])) begin
        vout_d[i] = adc_vout_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vin_q <= TELEMETRY_RESET;
      temp_q <= TELEMETRY_RESET;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        vout_q[i] <= TELEMETRY_RESET;
      end
    end else begin
      vin_q <= vin_d;
      temp_q <= temp_d;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        vout_q[i] <= vout_d[i];
      end
    end
  end

  // ****************************************************************
  // configuration storage
  // ****************************************************************

  // only the addressed page is touched; reserved nibble is never stored
  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      cfg_d[i] = cfg_q[i];
      if (cmd_valid && cmd_write && (cmd_code == CMD_CONFIG_WORD)
          && (cmd_page == i[CH_W-1:0])) begin
        cfg_d[i] = cmd_wdata & CONFIG_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        cfg_q[i] <= CONFIG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // ****************************************************************
  // command answers
  // ****************************************************************

  // reads answer one cycle after the request; writes to read-only words flag an error
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    error_d = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        CMD_INPUT_VOLTAGE: begin
          rdata_d = vin_q;
          error_d = cmd_write;
        end
        CMD_OUTPUT_VOLTAGE: begin
          rdata_d = vout_q[cmd_page];
          error_d = cmd_write;
        end
        CMD_JUNCTION_TEMP: begin
          rdata_d = temp_q;
          error_d = cmd_write;
        end
        CMD_PROTOCOL_REV: begin
          rdata_d = {8'h00, PROTOCOL_REVISION};
          error_d = cmd_write;
        end
        CMD_CONFIG_WORD: begin
          rdata_d = cfg_q[cmd_page] & CONFIG_WRITE_MASK;
        end
        default: begin
          // unknown code: answer zero and flag it
          rdata_d = 16'h0000;
          error_d = 1'b1;
        end
      endcase
      rvalid_d = ~cmd_write;
    end
  end

  // ****************************************************************
  // per-channel decode
  // ****************************************************************

  // decode runs every cycle so a control pin change reaches the channel in one edge
  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      fast_d[i] = ~cfg_q[i][CFG_FAST_SERVO_OFF];
      sup_d[i] = cfg_q[i][CFG_SUPERVISOR_RES];
      hires_d[i] = hires_of(cfg_q[i], i);
      fmt_d[i] = hires_of(cfg_q[i], i) ? FMT_LINEAR11 : FMT_LINEAR16;
      ctl_d[i] = cfg_q[i][CFG_CONTROL_SEL] ? control_pin_one : control_pin_zero;
      mode_d[2*i +: 2] = cfg_q[i][CFG_DAC_MODE_HI:CFG_DAC_MODE_LO];
      // continuous servo only meaningful in soft-connect-and-servo mode
      cont_d[i] = (mode_d[2*i +: 2] == DAC_SOFT_SERVO) & cfg_q[i][CFG_SERVO_CONT];
      warn_d[i] = (mode_d[2*i +: 2] == DAC_SOFT_SERVO) & ~cfg_q[i][CFG_SERVO_CONT]
                  & cfg_q[i][CFG_SERVO_ON_WARN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      error_q <= 1'b0;
      fast_q <= '0;
      sup_q <= '0;
      hires_q <= '0;
      ctl_q <= '0;
      cont_q <= '0;
      warn_q <= '0;
      mode_q <= '0;
      fmt_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      error_q <= error_d;
      fast_q <= fast_d;
      sup_q <= sup_d;
      hires_q <= hires_d;
      ctl_q <= ctl_d;
      cont_q <= cont_d;
      warn_q <= warn_d;
      mode_q <= mode_d;
      fmt_q <= fmt_d;
    end
  end

  // outputs straight from flip-flops
  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;
  assign cmd_error = error_q;
  assign fast_servo_en = fast_q;
  assign supervisor_coarse = sup_q;
  assign adc_hires = hires_q;
  assign channel_control = ctl_q;
  assign servo_continuous = cont_q;
  assign servo_on_warn = warn_q;
  assign dac_mode = mode_q;
  assign vout_format = fmt_q;

endmodule

// ===== hw/telemetry_pkg.sv
package telemetry_pkg;

  // ****************************************************************
  // channel and command space
  // ****************************************************************
  localparam int unsigned NUM_CHANNELS = 8;     // eight supply channels
  localparam int unsigned CH_W = 3;             // channel index width

  // command codes selected over the command port
  localparam logic [2:0] CMD_INPUT_VOLTAGE = 3'h0;
  localparam logic [2:0] CMD_OUTPUT_VOLTAGE = 3'h1;
  localparam logic [2:0] CMD_JUNCTION_TEMP = 3'h2;
  localparam logic [2:0] CMD_PROTOCOL_REV = 3'h3;
  localparam logic [2:0] CMD_CONFIG_WORD = 3'h4;

  // ****************************************************************
  // fixed values
  // ****************************************************************
  localparam logic [7:0] PROTOCOL_REVISION = 8'h11;      // revision 1.1
  localparam logic [15:0] CONFIG_WRITE_MASK = 16'h0fff;  // top nibble reserved
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] TELEMETRY_RESET = 16'h0000;

  // ****************************************************************
  // configuration word field positions
  // ****************************************************************
  localparam int unsigned CFG_FAST_SERVO_OFF = 11;
  localparam int unsigned CFG_SUPERVISOR_RES = 10;
  localparam int unsigned CFG_ADC_HIRES = 9;
  localparam int unsigned CFG_CONTROL_SEL = 8;
  localparam int unsigned CFG_SERVO_CONT = 7;
  localparam int unsigned CFG_SERVO_ON_WARN = 6;
  localparam int unsigned CFG_DAC_MODE_HI = 5;
  localparam int unsigned CFG_DAC_MODE_LO = 4;

  // dac mode encodings
  localparam logic [1:0] DAC_SOFT_SERVO = 2'h0;
  localparam logic [1:0] DAC_DISCONNECTED = 2'h1;
  localparam logic [1:0] DAC_IMMEDIATE = 2'h2;
  localparam logic [1:0] DAC_SOFT_ONLY = 2'h3;

  // output-voltage reading format
  localparam logic FMT_LINEAR16 = 1'b0;
  localparam logic FMT_LINEAR11 = 1'b1;

endpackage

// ===== testbench/telemetry_readout_and_channel_config_chk.sv
`timescale 1ns/100ps
module telemetry_readout_and_channel_config_chk(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_code,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_error,
  input wire logic adc_vin_valid,
  input wire logic [15:0] adc_vin_l11,
  input wire logic control_pin_zero,
  input wire logic control_pin_one,
  input wire logic [7:0] adc_hires,
  input wire logic [7:0] channel_control,
  input wire logic [7:0] servo_continuous,
  input wire logic [7:0] servo_on_warn,
  input wire logic [15:0] dac_mode,
  input wire logic [7:0] vout_format
);
  // ****************************************
  // shadow of the input voltage word
  // ****************************************
  logic [15:0] vin_d, vin_q; // last taken conversion
  logic [7:0] dm0; // channel has dac mode 00
  always_comb begin
    vin_d = vin_q;
    if (adc_vin_valid) begin
      vin_d = adc_vin_l11;
    end
    for (int i = 0; i < 8; i++) begin
      dm0[i] = (dac_mode[2*i +: 2] == 2'h0);
    end
  end
  // reset to zero to mirror the telemetry reset value
  always_ff @(posedge clk) begin
    vin_q <= rst ? 16'h0000 : vin_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [2:0] c);
    cmd_valid && !cmd_write && cmd_code == c;
  endsequence
  property p_rev; s_rd(3'h3) |=> cmd_rvalid && cmd_rdata == 16'h0011; endproperty
  property p_wr; cmd_valid && cmd_write && cmd_code < 3'h4 |=> cmd_error; endproperty
  property p_vin; s_rd(3'h0) |=> cmd_rvalid && cmd_rdata == $past(vin_q); endproperty
  property p_nib; s_rd(3'h4) |=> cmd_rdata[15:12] == 4'h0; endproperty
  property p_even; (adc_hires & 8'h55) == 8'h00; endproperty
  property p_fmt; vout_format == adc_hires; endproperty
  property p_cont; (servo_continuous & ~dm0) == 8'h00; endproperty
  property p_warn; (servo_on_warn & (servo_continuous | ~dm0)) == 8'h00; endproperty
  property p_ctl; control_pin_zero && control_pin_one |=> channel_control == 8'hff; endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  a_wr: assert property (p_wr) else $error("read-only write not refused");
  a_vin: assert property (p_vin) else $error("input voltage word wrong");
  a_nib: assert property (p_nib) else $error("config top nibble set");
  a_even: assert property (p_even) else $error("even channel high resolution");
  a_fmt: assert property (p_fmt) else $error("reading format wrong");
  a_cont: assert property (p_cont) else $error("continuous servo outside mode 00");
  a_warn: assert property (p_warn) else $error("re-servo on warning misqualified");
  a_ctl: assert property (p_ctl) else $error("control pin not followed");
endmodule
bind telemetry_readout_and_channel_config telemetry_readout_and_channel_config_chk chk (.*);

// ===== testbench/adc_sequencer_model.sv
`timescale 1ns/100ps
// ****************************************
// conversion source: one word per call
// ****************************************
module adc_sequencer_model(
  input wire logic clk,
  output logic adc_vin_valid,
  output logic [15:0] adc_vin_l11,
  output logic adc_vout_valid,
  output logic [2:0] adc_vout_ch,
  output logic [15:0] adc_vout_data,
  output logic adc_temp_valid,
  output logic [15:0] adc_temp_l11
);
  initial begin
    {adc_vin_valid, adc_vout_valid, adc_temp_valid} = 3'h0;
    {adc_vin_l11, adc_vout_data, adc_temp_l11, adc_vout_ch} = '0;
  end
  // k: 0 input voltage, 1 output voltage, 2 temperature
  task automatic send(input logic [1:0] k, input logic [2:0] c, input logic [15:0] w);
    @(posedge clk);
    adc_vin_valid <= (k == 2'h0);
    adc_vout_valid <= (k == 2'h1);
    adc_temp_valid <= (k == 2'h2);
    {adc_vin_l11, adc_vout_data, adc_temp_l11, adc_vout_ch} <= {w, w, w, c};
    @(posedge clk);
    {adc_vin_valid, adc_vout_valid, adc_temp_valid} <= 3'h0;
    // data is stale after the strobe, so show its inverse
    {adc_vin_l11, adc_vout_data, adc_temp_l11} <= {~w, ~w, ~w};
  endtask
endmodule

// ===== testbench/telemetry_readout_and_channel_config_tb.sv
`timescale 1ns/100ps
module telemetry_readout_and_channel_config_tb;
  import telemetry_pkg::*;
  logic clk = 0, rst = 1, cmd_valid = 0, cmd_write = 0, rv, er;
  logic control_pin_zero = 0, control_pin_one = 1;
  logic [2:0] cmd_code = 3'h0, cmd_page = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000, cmd_rdata, rd;
  logic adc_vin_valid, adc_vout_valid, adc_temp_valid, cmd_rvalid, cmd_error;
  logic [2:0] adc_vout_ch;
  logic [15:0] adc_vin_l11, adc_vout_data, adc_temp_l11, dac_mode;
  logic [7:0] fast_servo_en, supervisor_coarse, adc_hires, channel_control;
  logic [7:0] servo_continuous, servo_on_warn, vout_format;
  int mismatches = 0, checked = 0, cycles = 0;
  always #10 clk = ~clk;
  adc_sequencer_model adc (.clk(clk), .adc_vin_valid(adc_vin_valid),
    .adc_vin_l11(adc_vin_l11), .adc_vout_valid(adc_vout_valid), .adc_vout_ch(adc_vout_ch),
    .adc_vout_data(adc_vout_data), .adc_temp_valid(adc_temp_valid),
    .adc_temp_l11(adc_temp_l11));
  telemetry_readout_and_channel_config dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_error(cmd_error), .adc_vin_valid(adc_vin_valid), .adc_vin_l11(adc_vin_l11),
    .adc_vout_valid(adc_vout_valid), .adc_vout_ch(adc_vout_ch),
    .adc_vout_data(adc_vout_data), .adc_temp_valid(adc_temp_valid),
    .adc_temp_l11(adc_temp_l11), .control_pin_zero(control_pin_zero),
    .control_pin_one(control_pin_one), .fast_servo_en(fast_servo_en),
    .supervisor_coarse(supervisor_coarse), .adc_hires(adc_hires),
    .channel_control(channel_control), .servo_continuous(servo_continuous),
    .servo_on_warn(servo_on_warn), .dac_mode(dac_mode), .vout_format(vout_format));
  // ****************************************
  // command and compare helpers
  // ****************************************
  task automatic cmd(input logic w, input logic [2:0] c, p, input logic [15:0] d);
    @(posedge clk);
    {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} <= {1'b1, w, c, p, d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    // strobes stand only in the cycle after the taking edge, so look there
    #1 {rv, er, rd} = {cmd_rvalid, cmd_error, cmd_rdata};
    // decoded controls land one edge after the stored word
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang is cut after a generous cycle budget
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cmd(0, CMD_PROTOCOL_REV, 0, 0);
    chk("revision", rd, 16'h0011);
    chk("revision strobe", 16'(rv), 16'h0001);
    cmd(1, CMD_PROTOCOL_REV, 0, 16'h00ff);
    chk("revision write error", 16'(er), 16'h0001);
    cmd(0, CMD_PROTOCOL_REV, 0, 0);
    chk("revision after write", rd, 16'h0011);
    adc.send(2'h0, 0, 16'hd123);
    cmd(0, CMD_INPUT_VOLTAGE, 0, 0);
    chk("input voltage", rd, 16'hd123);
    adc.send(2'h1, 3, 16'h1234);
    cmd(0, CMD_OUTPUT_VOLTAGE, 3, 0);
    chk("output voltage", rd, 16'h1234);
    adc.send(2'h2, 0, 16'he0a5);
    cmd(0, CMD_JUNCTION_TEMP, 0, 0);
    chk("temperature", rd, 16'he0a5);
    cmd(1, CMD_CONFIG_WORD, 1, 16'hffff);
    cmd(1, CMD_CONFIG_WORD, 0, 16'h0200);
    cmd(0, CMD_CONFIG_WORD, 1, 0);
    chk("config ch1", rd, 16'h0fff);
    cmd(0, CMD_CONFIG_WORD, 0, 0);
    chk("config ch0", rd, 16'h0200);
    chk("hires", 16'(adc_hires[1:0]), 16'h0002);
    chk("format", 16'(vout_format[1:0]), 16'h0002);
    chk("fast servo", 16'(fast_servo_en[1:0]), 16'h0001);
    chk("supervisor", 16'(supervisor_coarse[1:0]), 16'h0002);
    chk("control sel", 16'(channel_control[1:0]), 16'h0002);
    chk("servo cont off mode", 16'(servo_continuous[1]), 16'h0000);
    cmd(1, CMD_CONFIG_WORD, 2, 16'h00c0);
    cmd(1, CMD_CONFIG_WORD, 3, 16'h0040);
    chk("servo cont", 16'(servo_continuous[3:2]), 16'h0001);
    chk("servo warn", 16'(servo_on_warn[3:2]), 16'h0002);
    for (int m = 0; m < 4; m++) begin
      cmd(1, CMD_CONFIG_WORD, 4, 16'(m) << 4);
      chk("dac mode", 16'(dac_mode[9:8]), 16'(m));
    end
    // pin levels change on the rising edge like every other input
    @(posedge clk);
    control_pin_zero <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("control pins", 16'(channel_control), 16'h00ff);
    complete_run();
  end
endmodule
